// [fsl_bus_cycle.sv]
// one timed flash bus cycle: write command or read a word
`timescale 1ns/100ps
module fsl_bus_cycle #(
  parameter int DW = 16,
  parameter int AW = 21
) (
  input wire logic clk_sys, // system clock
  input wire logic rstn, // async reset, active low
  input wire logic start, // begin a cycle, one-cycle pulse
  input wire logic is_read, // 1 read, 0 write
  input wire logic [AW-1:0] addr, // address for the cycle
  input wire logic [DW-1:0] wdata, // data for a write
  input wire logic [DW-1:0] dq_in_s, // synchronised data pins
  output logic busy, // cycle in progress
  output logic done, // one-cycle pulse at end
  output logic [DW-1:0] rdata, // captured read data
  output logic [AW-1:0] fa, // flash address pins
  output logic [DW-1:0] dq_out, // data out
  output logic dq_oe, // data drive enable
  output logic ce_n, // chip enable, low active
  output logic we_n, // write enable, low active
  output logic oe_n // output enable, low active
);
  localparam logic [7:0] PULSE = 8'(fsl_pkg::T_PULSE_CYC);
  // read waits for access time plus the synchroniser's two flops
  localparam logic [7:0] ACC = 8'(fsl_pkg::T_ACCESS_CYC + 2);
  logic [7:0] cnt_reg;
  logic rd_reg;
  wire last = busy && (cnt_reg == 8'h01);
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cnt_reg <= '0;
      rd_reg <= 1'b0;
      busy <= 1'b0;
      done <= 1'b0;
      rdata <= '0;
      fa <= '0;
      dq_out <= '0;
      dq_oe <= 1'b0;
      ce_n <= 1'b1;
      we_n <= 1'b1;
      oe_n <= 1'b1;
    end else begin
      done <= last;
      if (start && !busy) begin
        busy <= 1'b1;
        rd_reg <= is_read;
        cnt_reg <= is_read ? ACC : PULSE;
        fa <= addr;
        dq_out <= wdata;
        dq_oe <= !is_read;
        ce_n <= 1'b0;
        we_n <= is_read;
        oe_n <= !is_read;
      end else if (last) begin
        // data latched by the device mid pulse, before we_n rises here
        busy <= 1'b0;
        cnt_reg <= '0;
        if (rd_reg) rdata <= dq_in_s;
        ce_n <= 1'b1;
        we_n <= 1'b1;
        oe_n <= 1'b1;
        dq_oe <= 1'b0;
      end else if (busy) begin
        cnt_reg <= cnt_reg - 8'h01;
      end
    end
  end
endmodule

// [fsl_flash_model.sv]
// flash device model: status register, suspend, resume and lock bits
`timescale 1ns/100ps
module fsl_flash_model (
  input wire logic ce_n, // chip enable
  input wire logic we_n, // write enable
  input wire logic oe_n, // output enable
  input wire logic [20:0] fa, // address
  input wire logic [15:0] dq, // data bus level
  input wire logic rp_n, // reset, low active
  input wire logic wp_n, // write protect
  input wire logic vpp_low, // supply below lockout
  input wire logic go_erase, // start a long erase
  input wire logic go_write, // start a long write
  output logic [15:0] dq_m, // read data
  output logic m_oe, // read drive enable
  output logic sts_low // status pin pulled low
);
  localparam time T_WSM = 300; // arbitrary algorithm latency
  logic busy = 1'b0, ek = 1'b0, esus = 1'b0, wsus = 1'b0, setup = 1'b0;
  logic eerr = 1'b0, werr = 1'b0, vlow = 1'b0, viol = 1'b0, rd_sr = 1'b1;
  logic [7:0] c;
  wire [7:0] sr = {!busy, esus, eerr, werr, vlow, wsus, viol, 1'b0};
  wire conf = c == fsl_pkg::CMD_SET_LOCK_CONFIRM;
  wire cconf = c == fsl_pkg::CMD_CLEAR_LOCK_CONFIRM;
  assign m_oe = !ce_n && !oe_n;
  assign dq_m = rd_sr ? {8'h00, sr} : fa[15:0] ^ 16'hA5A5;
  assign sts_low = busy;
  task automatic run();
    busy = 1'b1;
    busy <= #T_WSM 1'b0;
  endtask
  // the latest long job decides which suspend flag a suspend sets
  always @(posedge go_erase) {ek, busy} = 2'b11;
  always @(posedge go_write) {ek, busy} = 2'b01;
  // aborted work is simply lost, the host must repeat it
  always @(negedge rp_n) {busy, esus, wsus, setup} = 4'h0;
  // ====================
  // command decoding, data latched mid pulse
  always begin
    @(negedge we_n);
    #30 c = dq[7:0];
    @(posedge we_n);
    if (setup) begin
      setup = 1'b0;
      if (conf && !wp_n) {viol, werr} = 2'b11;
      else if (cconf && vpp_low) {vlow, eerr} = 2'b11;
      else if (cconf && !wp_n) {viol, eerr} = 2'b11;
      else if (conf || cconf) run();
      else {werr, eerr} = 2'b11;
    end else if (c == fsl_pkg::CMD_LOCK_SETUP) setup = 1'b1;
    else if (c == fsl_pkg::CMD_CLEAR_STATUS) {eerr, werr, vlow, viol} = 4'h0;
    else if (c == fsl_pkg::CMD_ERASE_SUSPEND && busy) begin
      if (ek) esus <= #T_WSM 1'b1;
      else wsus <= #T_WSM 1'b1;
      busy <= #T_WSM 1'b0;
    end else if (c == fsl_pkg::CMD_WRITE_RESUME && wsus) begin
      wsus = 1'b0;
      run();
    end else if (c == fsl_pkg::CMD_ERASE_RESUME && esus && !busy) begin
      esus = 1'b0;
      ek = 1'b1;
      run();
    end
    rd_sr = c != fsl_pkg::CMD_READ_ARRAY;
  end
endmodule

// [fsl_host.sv]
// host controller for flash suspend, resume and lock-bit commands
//
// Function
// - during erase suspend, read/write other blocks; the host only issues array reads, it has no write command
// - erase suspend allows read, status, resume and write suspend
// - hold reset high, protect pin stable
// - write suspend allows read, status, resume only
// - set lock: setup write then confirm write
// - poll ready, check write error, clear; the host only polls ready and leaves error check and clear to software
// - after clear, check erase error, clear; the host only polls ready and leaves error check and clear to software
// - aborted clear must be repeated; the host never reissues it, software must
//
// Chosen here: the address-and-strobe port and the register addresses.
`timescale 1ns/100ps
module fsl_host #(
  parameter int DW = 16,
  parameter int AW = 21,
  parameter int POLL_LIMIT = fsl_pkg::T_POLL_TIMEOUT_CYC,
  parameter logic [7:0] OPC_ERASE_SUSPEND = fsl_pkg::CMD_ERASE_SUSPEND,
  parameter logic [7:0] OPC_ERASE_RESUME = fsl_pkg::CMD_ERASE_RESUME,
  parameter logic [7:0] OPC_WRITE_SUSPEND = fsl_pkg::CMD_WRITE_SUSPEND,
  parameter logic [7:0] OPC_WRITE_RESUME = fsl_pkg::CMD_WRITE_RESUME,
  parameter logic [7:0] OPC_LOCK_SETUP = fsl_pkg::CMD_LOCK_SETUP,
  parameter logic [7:0] OPC_SET_CONFIRM = fsl_pkg::CMD_SET_LOCK_CONFIRM,
  parameter logic [7:0] OPC_CLR_CONFIRM = fsl_pkg::CMD_CLEAR_LOCK_CONFIRM
) (
  input wire logic clk_sys, // system clock, 100 MHz
  input wire logic rstn, // async reset, active low
  input wire logic [3:0] reg_addr, // register index
  input wire logic [31:0] reg_wdata, // register write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  output logic [31:0] reg_rdata, // read data, cycle after strobe
  input wire logic sts_in, // device status pin, pulled up
  input wire logic [DW-1:0] dq_in, // flash data pins in
  output logic [DW-1:0] dq_out, // flash data pins out
  output logic dq_oe, // flash data drive enable
  output logic [AW-1:0] fa, // flash address
  output logic ce_n, // chip enable, low active
  output logic we_n, // write enable, low active
  output logic oe_n, // output enable, low active
  output logic reset_powerdown_n, // device reset, low active
  output logic write_protect_n // device write protect, low active
);
  // ==========================================================
  // state machine
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_CMD1 = 3'b001,
    S_CMD2 = 3'b010,
    S_POLL = 3'b011,
    S_WAIT = 3'b100,
    S_READ = 3'b101
  } fsl_state_t;

  // suspend context the host tracks to police the command set
  typedef enum logic [1:0] {
    C_NONE = 2'b00,
    C_ERASE_SUSP = 2'b01,
    C_WRITE_SUSP = 2'b10
  } fsl_ctx_t;

  fsl_state_t state_reg, state_next;
  fsl_ctx_t ctx_reg;
  logic [3:0] op_reg;
  logic [AW-1:0] addr_reg;
  logic [7:0] sr_reg;
  logic [DW-1:0] rword_reg;
  logic [31:0] poll_cnt_reg;
  logic done_flag_reg, refused_reg, timeout_reg, nest_busy_reg;
  logic wp_reg, rp_reg, ro_reg;
  logic start_reg, is_read_reg, op_is_poll_r;
  logic [DW-1:0] wdata_reg;
  logic [31:0] rdata_reg;
  logic cyc_done, sts_s;
  logic [DW-1:0] cyc_rdata, dq_s;

  // ==========================================================
  // pin synchronisers
  fsl_sync #(.WIDTH(DW + 1)) u_sync (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .d_in({sts_in, dq_in}),
    .d_out({sts_s, dq_s})
  );

  fsl_bus_cycle #(.DW(DW), .AW(AW)) u_cyc (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .start(start_reg),
    .is_read(is_read_reg),
    .addr(addr_reg),
    .wdata(wdata_reg),
    .dq_in_s(dq_s),
    .busy(),
    .done(cyc_done),
    .rdata(cyc_rdata),
    .fa(fa),
    .dq_out(dq_out),
    .dq_oe(dq_oe),
    .ce_n(ce_n),
    .we_n(we_n),
    .oe_n(oe_n)
  );

  // ==========================================================
  // command decode
  function automatic logic [7:0] first_opc(input logic [3:0] op);
    unique case (op)
      fsl_pkg::OP_ERASE_SUSPEND: first_opc = OPC_ERASE_SUSPEND;
      fsl_pkg::OP_ERASE_RESUME: first_opc = OPC_ERASE_RESUME;
      fsl_pkg::OP_WRITE_SUSPEND: first_opc = OPC_WRITE_SUSPEND;
      fsl_pkg::OP_WRITE_RESUME: first_opc = OPC_WRITE_RESUME;
      fsl_pkg::OP_SET_LOCK: first_opc = OPC_LOCK_SETUP;
      fsl_pkg::OP_CLEAR_LOCK: first_opc = OPC_LOCK_SETUP;
      fsl_pkg::OP_READ_ARRAY: first_opc = fsl_pkg::CMD_READ_ARRAY;
      fsl_pkg::OP_CLEAR_STATUS: first_opc = fsl_pkg::CMD_CLEAR_STATUS;
      default: first_opc = fsl_pkg::CMD_READ_STATUS;
    endcase
  endfunction

  wire ctrl_wr = reg_wr && (reg_addr == fsl_pkg::REG_CTRL);
  wire addr_wr = reg_wr && (reg_addr == fsl_pkg::REG_ADDR);
  wire [3:0] new_op = reg_wdata[3:0];
  wire op_is_lock = (new_op == fsl_pkg::OP_SET_LOCK) ||
                    (new_op == fsl_pkg::OP_CLEAR_LOCK);
  wire op_is_poll = (new_op != fsl_pkg::OP_READ_ARRAY) &&
                    (new_op != fsl_pkg::OP_CLEAR_STATUS);
  // legal commands per suspend context
  wire allow_erase_susp = (new_op == fsl_pkg::OP_READ_ARRAY) ||
                          (new_op == fsl_pkg::OP_READ_STATUS) ||
                          (new_op == fsl_pkg::OP_ERASE_RESUME) ||
                          (new_op == fsl_pkg::OP_WRITE_SUSPEND);
  wire allow_write_susp = (new_op == fsl_pkg::OP_READ_ARRAY) ||
                          (new_op == fsl_pkg::OP_READ_STATUS) ||
                          (new_op == fsl_pkg::OP_WRITE_RESUME);
  wire allow_none = (new_op != fsl_pkg::OP_ERASE_RESUME) &&
                    (new_op != fsl_pkg::OP_WRITE_RESUME) &&
                    (new_op != 4'h0) && (new_op <= 4'h9);
  wire legal = (ctx_reg == C_ERASE_SUSP) ? allow_erase_susp :
               (ctx_reg == C_WRITE_SUSP) ? allow_write_susp : allow_none;
  // erase resume refused while a nested write is still busy
  wire resume_blocked = (new_op == fsl_pkg::OP_ERASE_RESUME) &&
                        nest_busy_reg;
  wire accept = ctrl_wr && (state_reg == S_IDLE) && legal &&
                !resume_blocked;
  wire reject = ctrl_wr && !accept;
  wire second_cycle = (op_reg == fsl_pkg::OP_SET_LOCK) ||
                      (op_reg == fsl_pkg::OP_CLEAR_LOCK);
  wire [7:0] confirm_opc = (op_reg == fsl_pkg::OP_SET_LOCK) ?
                           OPC_SET_CONFIRM : OPC_CLR_CONFIRM;
  wire [7:0] rd_sr = cyc_rdata[7:0];
  wire ready_now = rd_sr[fsl_pkg::SR_READY] && sts_s;
  wire susp_target = (op_reg == fsl_pkg::OP_ERASE_SUSPEND) ?
                     rd_sr[fsl_pkg::SR_ERASE_SUSP] :
                     (op_reg == fsl_pkg::OP_WRITE_SUSPEND) ?
                     rd_sr[fsl_pkg::SR_WRITE_SUSP] : 1'b1;
  wire poll_over = (poll_cnt_reg == 32'(POLL_LIMIT));
  wire is_suspend = (op_reg == fsl_pkg::OP_ERASE_SUSPEND) ||
                    (op_reg == fsl_pkg::OP_WRITE_SUSPEND);

  // ==========================================================
  // sequencer
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      S_IDLE: if (accept) state_next = S_CMD1;
      S_CMD1: if (cyc_done) state_next = second_cycle ? S_CMD2 :
                (op_reg == fsl_pkg::OP_READ_ARRAY) ? S_READ :
                (op_is_poll_r ? S_POLL : S_IDLE);
      S_CMD2: if (cyc_done) state_next = S_POLL;
      S_POLL: if (cyc_done) state_next = S_WAIT;
      S_WAIT: if (ready_now && susp_target) state_next = S_IDLE;
              else if (poll_over) state_next = S_IDLE;
              else state_next = S_POLL;
      S_READ: if (cyc_done) state_next = S_IDLE;
      default: state_next = S_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) state_reg <= S_IDLE;
    else state_reg <= state_next;
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      op_reg <= '0;
      op_is_poll_r <= 1'b0;
    end else if (accept) begin
      op_reg <= new_op;
      op_is_poll_r <= op_is_poll;
    end
  end

  // bus cycle requests; after suspend/resume/lock the device answers
  // with status, so polls need no extra read-status command
  wire launch = (state_reg == S_IDLE && accept) ||
                (state_reg == S_CMD1 && cyc_done && second_cycle) ||
                (state_reg == S_CMD1 && cyc_done &&
                 op_reg == fsl_pkg::OP_READ_ARRAY) ||
                (state_reg == S_CMD1 && cyc_done && op_is_poll_r &&
                 !second_cycle) ||
                (state_reg == S_CMD2 && cyc_done) ||
                (state_reg == S_WAIT && state_next == S_POLL);
  wire launch_rd = (state_reg != S_IDLE) &&
                   !(state_reg == S_CMD1 && second_cycle);
  wire [DW-1:0] launch_data = (state_reg == S_IDLE) ?
                              DW'(first_opc(new_op)) : DW'(confirm_opc);
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      start_reg <= 1'b0;
      is_read_reg <= 1'b0;
      wdata_reg <= '0;
    end else begin
      start_reg <= launch;
      if (launch) begin
        is_read_reg <= launch_rd;
        wdata_reg <= launch_data;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) addr_reg <= '0;
    else if (addr_wr) addr_reg <= reg_wdata[AW-1:0];
  end

  // ==========================================================
  // captured status and context
  wire finish = (state_reg == S_WAIT) && (state_next == S_IDLE);
  wire op_ok = ready_now && susp_target;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      sr_reg <= fsl_pkg::RESET_SR;
      ctx_reg <= C_NONE;
      nest_busy_reg <= 1'b0;
      timeout_reg <= 1'b0;
      rword_reg <= '0;
    end else begin
      if (state_reg == S_WAIT) sr_reg <= rd_sr;
      if (state_reg == S_READ && cyc_done) rword_reg <= cyc_rdata;
      // a nested write in erase suspend shows busy with flag held
      if (state_reg == S_WAIT && ctx_reg == C_ERASE_SUSP)
        nest_busy_reg <= !rd_sr[fsl_pkg::SR_READY] &&
                         rd_sr[fsl_pkg::SR_ERASE_SUSP];
      if (finish && op_ok) begin
        unique case (op_reg)
          fsl_pkg::OP_ERASE_SUSPEND: ctx_reg <= C_ERASE_SUSP;
          fsl_pkg::OP_WRITE_SUSPEND: ctx_reg <= C_WRITE_SUSP;
          fsl_pkg::OP_ERASE_RESUME: ctx_reg <= C_NONE;
          fsl_pkg::OP_WRITE_RESUME: ctx_reg <= rd_sr[fsl_pkg::SR_ERASE_SUSP]
                                     ? C_ERASE_SUSP : C_NONE;
          default: ctx_reg <= ctx_reg;
        endcase
      end
      if (accept) timeout_reg <= 1'b0;
      else if (finish && !op_ok) timeout_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) poll_cnt_reg <= '0;
    else if (accept) poll_cnt_reg <= '0;
    else if (state_reg == S_WAIT && !poll_over)
      poll_cnt_reg <= poll_cnt_reg + 32'h0000_0001;
  end

  // done and refused are sticky; a new done wins over a clear, a clear wins over a new refusal
  wire clr_sticky = ctrl_wr && reg_wdata[31];
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      done_flag_reg <= 1'b0;
      refused_reg <= 1'b0;
    end else begin
      // clear status ends straight after its command cycle, read array after its read
      done_flag_reg <= finish || (state_reg == S_READ && cyc_done) ||
                       (state_reg == S_CMD1 && cyc_done &&
                        state_next == S_IDLE) ||
                       (done_flag_reg && !clr_sticky && !accept);
      refused_reg <= (reject && !clr_sticky) ||
                     (refused_reg && !clr_sticky);
    end
  end

  // reset and protect held steady unless software changes them
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rp_reg <= 1'b0;
      wp_reg <= 1'b0;
      ro_reg <= 1'b0;
    end else begin
      ro_reg <= 1'b1;
      rp_reg <= ro_reg;
      // protect pin only moves while no suspend is in force
      if (ctrl_wr && reg_wdata[30] && ctx_reg == C_NONE &&
          state_reg == S_IDLE)
        wp_reg <= reg_wdata[8];
    end
  end
  assign reset_powerdown_n = rp_reg;
  assign write_protect_n = wp_reg;

  // ==========================================================
  // register read port
  wire [31:0] status_word = {22'h0, is_suspend, timeout_reg, refused_reg,
                             done_flag_reg, ctx_reg, sts_s,
                             state_reg != S_IDLE, wp_reg, rp_reg};
  wire [31:0] rd_mux = (reg_addr == fsl_pkg::REG_CTRL) ? {28'h0, op_reg} :
                       (reg_addr == fsl_pkg::REG_ADDR) ? 32'(addr_reg) :
                       (reg_addr == fsl_pkg::REG_STATUS) ? status_word :
                       (reg_addr == fsl_pkg::REG_FLASH_SR) ? 32'(sr_reg) :
                       (reg_addr == fsl_pkg::REG_RDATA) ? 32'(rword_reg) :
                       32'h0000_0000;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) rdata_reg <= '0;
    else if (reg_rd) rdata_reg <= rd_mux;
    else rdata_reg <= '0;
  end
  assign reg_rdata = rdata_reg;
endmodule

// [fsl_pkg.sv]
// package: command codes, status bits, register map and timing for the flash host
package fsl_pkg;
  // command opcodes, configurable
  localparam logic [7:0] CMD_ERASE_SUSPEND = 8'hB0;
  localparam logic [7:0] CMD_ERASE_RESUME = 8'hD0;
  localparam logic [7:0] CMD_WRITE_SUSPEND = 8'hB0;
  localparam logic [7:0] CMD_WRITE_RESUME = 8'hD0;
  localparam logic [7:0] CMD_LOCK_SETUP = 8'h60;
  localparam logic [7:0] CMD_SET_LOCK_CONFIRM = 8'h01;
  localparam logic [7:0] CMD_CLEAR_LOCK_CONFIRM = 8'hD0;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
  // status register bit positions
  localparam int SR_READY = 7;
  localparam int SR_ERASE_SUSP = 6;
  localparam int SR_ERASE_ERR = 5;
  localparam int SR_WRITE_ERR = 4;
  localparam int SR_VPP_LOW = 3;
  localparam int SR_WRITE_SUSP = 2;
  localparam int SR_LOCK_VIOL = 1;
  // host register offsets
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_ADDR = 4'h1;
  localparam logic [3:0] REG_STATUS = 4'h2;
  localparam logic [3:0] REG_FLASH_SR = 4'h3;
  localparam logic [3:0] REG_RDATA = 4'h4;
  // control codes written to the ctrl register
  localparam logic [3:0] OP_ERASE_SUSPEND = 4'h1;
  localparam logic [3:0] OP_ERASE_RESUME = 4'h2;
  localparam logic [3:0] OP_WRITE_SUSPEND = 4'h3;
  localparam logic [3:0] OP_WRITE_RESUME = 4'h4;
  localparam logic [3:0] OP_SET_LOCK = 4'h5;
  localparam logic [3:0] OP_CLEAR_LOCK = 4'h6;
  localparam logic [3:0] OP_READ_ARRAY = 4'h7;
  localparam logic [3:0] OP_CLEAR_STATUS = 4'h8;
  localparam logic [3:0] OP_READ_STATUS = 4'h9;
  // flash bus timing
  localparam int CLK_NS = 10;
  localparam int T_PULSE_NS = 60;
  localparam int T_PULSE_CYC = (T_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_ACCESS_NS = 100;
  localparam int T_ACCESS_CYC = (T_ACCESS_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_POLL_TIMEOUT_CYC = 8_000_000;
  localparam logic [7:0] RESET_SR = 8'h00;
endpackage

// [fsl_properties.sv]
// checker: protocol relations at the flash host ports
`timescale 1ns/100ps
module fsl_properties (
  input wire logic clk_sys, // clock
  input wire logic rstn, // reset, active low
  input wire logic [3:0] reg_addr, // register index
  input wire logic [31:0] reg_wdata, // write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  input wire logic [31:0] reg_rdata, // read data
  input wire logic [15:0] dq_out, // data out
  input wire logic dq_oe, // data drive enable
  input wire logic [20:0] fa, // flash address
  input wire logic ce_n, // chip enable
  input wire logic we_n, // write enable
  input wire logic oe_n, // output enable
  input wire logic reset_powerdown_n, // device reset
  input wire logic write_protect_n // write protect
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // ====================
  // assertions
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
    else $error("read data outside read slot");
  strobe_excl_a: assert property (!(!we_n && !oe_n))
    else $error("write and output enable both low");
  write_sel_a: assert property (!we_n |-> !ce_n)
    else $error("write strobe without chip enable");
  bus_turn_a: assert property (dq_oe |-> oe_n)
    else $error("host drives data while device outputs");
  reset_held_a: assert property (reset_powerdown_n |=> reset_powerdown_n)
    else $error("device reset dropped in operation");
  protect_src_a: assert property ($changed(write_protect_n) |->
    $past(reg_wr) && $past(reg_addr) == fsl_pkg::REG_CTRL && $past(reg_wdata[30]))
    else $error("write protect moved without request");
  write_pulse_a: assert property ($fell(we_n) |-> (!we_n) [*6] ##1 we_n)
    else $error("write pulse not six cycles");
  write_hold_a: assert property (!we_n && !$fell(we_n) |->
    $stable(fa) && $stable(dq_out) && dq_oe)
    else $error("address or data moved in write pulse");
  cover property ($fell(we_n));
  cover property ($fell(oe_n));
  cover property ($rose(write_protect_n));
endmodule

// [fsl_sync.sv]
// two-flop synchroniser for a pin input
`timescale 1ns/100ps
module fsl_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_sys, // system clock
  input wire logic rstn, // async reset, active low
  input wire logic [WIDTH-1:0] d_in, // asynchronous input
  output logic [WIDTH-1:0] d_out // synchronised level
);
  logic [WIDTH-1:0] meta_reg;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      meta_reg <= '0;
      d_out <= '0;
    end else begin
      meta_reg <= d_in;
      d_out <= meta_reg;
    end
  end
endmodule

// [fsl_tb.sv]
// testbench: flash host driven through its registers against a flash model
`timescale 1ns/100ps
module testbench;
  logic clk_sys = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic go_erase = 1'b0, go_write = 1'b0, vpp_low = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0000_0000, reg_rdata, s, f;
  logic [15:0] dq_out, dq_m, dq_last = 16'h0000;
  logic dq_oe, m_oe, sts_low, ce_n, we_n, oe_n, rp_n, wp_n;
  logic [20:0] fa;
  int n_fail = 0, num_checks = 0, cyc = 0;
  // a released bus shows the inverse of its last value
  wire [15:0] dq_w = dq_oe ? dq_out : m_oe ? dq_m : ~dq_last;
  fsl_host #(.POLL_LIMIT(200)) fsl_host_inst (.clk_sys(clk_sys), .rstn(rstn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sts_in(!sts_low), .dq_in(dq_w),
    .dq_out(dq_out), .dq_oe(dq_oe), .fa(fa), .ce_n(ce_n), .we_n(we_n),
    .oe_n(oe_n), .reset_powerdown_n(rp_n), .write_protect_n(wp_n));
  fsl_flash_model fsl_flash_model_inst (.ce_n(ce_n), .we_n(we_n), .oe_n(oe_n),
    .fa(fa), .dq(dq_w), .rp_n(rp_n), .wp_n(wp_n), .vpp_low(vpp_low),
    .go_erase(go_erase), .go_write(go_write), .dq_m(dq_m), .m_oe(m_oe),
    .sts_low(sts_low));
  initial forever #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    if (dq_oe || m_oe) dq_last <= dq_w;
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_fail++;
      wrap_up();
    end
  end
  // ====================
  // bus tasks
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic ok, input string m);
    num_checks++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("MISMATCH t=%0t %s", $time, m);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // clears sticky bits, runs one op, polls done or refused
  task automatic op(input logic [3:0] c);
    wr(fsl_pkg::REG_CTRL, 32'h8000_0000);
    wr(fsl_pkg::REG_CTRL, {28'h000_0000, c});
    s = 32'h0000_0000;
    for (int i = 0; i < 100 && s[7:6] === 2'b00; i++)
      rd(fsl_pkg::REG_STATUS, s);
    chk(s[7:6] !== 2'b00, "op never ended");
    rd(fsl_pkg::REG_FLASH_SR, f);
  endtask
  // ====================
  // scenarios
  task automatic t_reset();
    rd(fsl_pkg::REG_STATUS, s);
    chk(s[1:0] === 2'b01 && rp_n === 1'b1, "pins after reset");
    rd(4'hF, s);
    chk(s === 32'h0000_0000, "unmapped read");
    op(fsl_pkg::OP_ERASE_RESUME);
    chk(s[7] === 1'b1, "resume without suspend");
    op(fsl_pkg::OP_READ_STATUS);
    chk(s[7:6] === 2'b01 && f[7] === 1'b1, "status poll");
  endtask
  task automatic t_erase();
    wr(fsl_pkg::REG_ADDR, 32'h0000_1234);
    go_erase <= 1'b1;
    op(fsl_pkg::OP_ERASE_SUSPEND);
    chk(s[7:6] === 2'b01 && s[5:4] === 2'd1, "erase suspend");
    chk(f[7:6] === 2'b11 && s[3] === 1'b1, "suspend flags");
    op(fsl_pkg::OP_READ_ARRAY);
    rd(fsl_pkg::REG_RDATA, f);
    chk(f[15:0] === (16'h1234 ^ 16'hA5A5), "array word");
    op(fsl_pkg::OP_WRITE_RESUME);
    chk(s[7] === 1'b1, "write resume in erase suspend");
    op(fsl_pkg::OP_ERASE_RESUME);
    chk(s[7:4] === 4'b0100 && f[7:6] === 2'b10, "erase resume");
  endtask
  task automatic t_write();
    go_write <= 1'b1;
    op(fsl_pkg::OP_WRITE_SUSPEND);
    chk(s[5:4] === 2'd2 && f[7] === 1'b1 && f[2] === 1'b1, "wr susp");
    op(fsl_pkg::OP_ERASE_SUSPEND);
    chk(s[7] === 1'b1, "erase suspend in write suspend");
    op(fsl_pkg::OP_WRITE_RESUME);
    chk(s[5:4] === 2'd0 && f[7] === 1'b1 && f[2] === 1'b0, "wr res");
  endtask
  // set ok, set protected, clear protected, clear low supply, clear ok
  task automatic t_lock();
    logic [4:0] exp[5] = '{5'h00, 5'h09, 5'h11, 5'h14, 5'h00};
    for (int k = 0; k < 5; k++) begin
      logic wpv;
      wpv = k != 1 && k != 2;
      vpp_low <= k == 3;
      wr(fsl_pkg::REG_CTRL, {2'b01, 21'h00_0000, wpv, 8'h00});
      op(fsl_pkg::OP_CLEAR_STATUS);
      chk(wp_n === wpv && s[1] === wpv, "protect pin");
      op(k < 2 ? fsl_pkg::OP_SET_LOCK : fsl_pkg::OP_CLEAR_LOCK);
      chk(s[6] === 1'b1 && f[5:1] === exp[k], "lock");
    end
  endtask
  initial begin
    repeat (8) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (4) @(posedge clk_sys);
    t_reset();
    t_erase();
    t_write();
    t_lock();
    wrap_up();
  end
endmodule
bind fsl_host fsl_properties fsl_properties_inst (.clk_sys(clk_sys),
  .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .dq_out(dq_out), .dq_oe(dq_oe),
  .fa(fa), .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n),
  .reset_powerdown_n(reset_powerdown_n), .write_protect_n(write_protect_n));
